//--- inc/dor_map.svh
`ifndef DOR_MAP_SVH
`define DOR_MAP_SVH
// Register indexes on the plain port (word address)
`define DOR_ADDR_W          4
`define DOR_IDX_ENTRY0      4'h0
`define DOR_NUM_OUT         4
`define DOR_IDX_CTRL        4'h8
`define DOR_IDX_CTRLWORD    4'h9
`define DOR_IDX_PINS        4'ha
`define DOR_IDX_BRAKE_PER   4'hb
`define DOR_IDX_BRAKE_ON    4'hc
// Field positions and values
`define DOR_ROUTE_EN_BIT    0
`define DOR_INV_BIT         7
`define DOR_SEL_MSB         4
`define DOR_ENTRY_RESET     16'hffff
`define DOR_ENTRY_OFF       16'hffff
`define DOR_SRC_ONE         8'h00
`define DOR_SRC_ZERO        8'h01
`define DOR_SRC_ENC_LO      8'h02
`define DOR_SRC_ENC_HI      8'h08
`define DOR_SRC_POS_LO      8'h09
`define DOR_SRC_POS_HI      8'h0f
`define DOR_SRC_BRAKE       8'h10
`define DOR_SRC_BRAKE_N     8'h11
`define DOR_BRAKE_BIT       0
// Timing: clock and output frequency limits
`define DOR_CLK_HZ          25000000
`define DOR_SWPWM_MAX_HZ    2000
`define DOR_OUT_MAX_HZ      500
// Least cycles between toggles (half period), rounded up
`define DOR_SWPWM_GAP  ((`DOR_CLK_HZ + 2*`DOR_SWPWM_MAX_HZ - 1) / (2*`DOR_SWPWM_MAX_HZ))
`define DOR_OUT_GAP    ((`DOR_CLK_HZ + 2*`DOR_OUT_MAX_HZ - 1) / (2*`DOR_OUT_MAX_HZ))
`endif

//--- inc/dor_pkg.sv
package dor_pkg;
    // Bus request carrier
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } dor_bus_t;
    // One routing entry
    typedef struct packed {
        logic [7:0] src;
        logic [7:0] gate;
    } dor_entry_t;
    // Pulse shaper states
    typedef enum logic [1:0] {
        DOR_IDLE = 2'b00,
        DOR_HIGH = 2'b01,
        DOR_LOW  = 2'b10
    } dor_shape_t;
endpackage : dor_pkg

//--- hw/dor_divider.sv
`include "dor_map.svh"
// Divides an increment strobe by 2**sel, sel 0..6
module dor_divider
    import dor_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       inc,
    input  wire logic [2:0] sel,
    output      logic       tick
);
    // State of the divider
    typedef struct packed {
        logic [5:0] cnt;
        logic       tick;
    } dor_div_st_t;
    dor_div_st_t st, next_st;
    logic [5:0] lim;
    // Terminal count from selection
    assign lim = 6'((7'h01 << sel) - 7'h01);
    // Count increments, tick on wrap
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (inc) begin
            if (st.cnt >= lim) begin
                next_st.cnt  = 6'h00;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 6'h01;
            end
        end
    end
    // Register state
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign tick = st.tick;
endmodule : dor_divider

//--- hw/dor_shaper.sv
`include "dor_map.svh"
// Turns ticks into pulses with a least high and low time; extra ticks are counted
module dor_shaper
    import dor_pkg::*;
#(
    parameter int GAP = 1
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic tick,
    output      logic pulse
);
    typedef struct packed {
        dor_shape_t  state;
        logic [15:0] cnt;
        logic [7:0]  pend;
    } dor_shp_st_t;
    localparam logic [15:0] GAP_M1 = 16'(GAP - 1);
    dor_shp_st_t st, next_st;
    logic [7:0] pend_in;
    // Saturating count of waiting ticks
    assign pend_in = (tick && st.pend != 8'hff) ? st.pend + 8'h01 : st.pend;
    // Shaper machine
    always_comb begin
        next_st = st;
        next_st.pend = pend_in;
        unique case (st.state)
            DOR_IDLE: begin
                if (pend_in != 8'h00) begin
                    next_st.state = DOR_HIGH;
                    next_st.cnt   = 16'h0000;
                    next_st.pend  = pend_in - 8'h01;
                end
            end
            DOR_HIGH: begin
                if (st.cnt >= GAP_M1) begin
                    next_st.state = DOR_LOW;
                    next_st.cnt   = 16'h0000;
                end else begin
                    next_st.cnt = st.cnt + 16'h0001;
                end
            end
            DOR_LOW: begin
                if (st.cnt >= GAP_M1) begin
                    next_st.state = DOR_IDLE;
                end else begin
                    next_st.cnt = st.cnt + 16'h0001;
                end
            end
            default: begin
                next_st.state = DOR_IDLE;
            end
        endcase
    end
    // Register state
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '{DOR_IDLE, 16'h0000, 8'h00};
        end else begin
            st <= next_st;
        end
    end
    assign pulse = (st.state == DOR_HIGH);
endmodule : dor_shaper

//--- hw/dor_route.sv
// Functional notes
// - Entry 0 software PWM, entry 1+ outputs
// - Software PWM 2 kHz, others 500 Hz
// - Entry: high byte source, low gate
// - Bit 7 inverts the gating bit sense
// - Entry value ffff disables that output
// - Source 00 constant one, 01 zero
// - Sources 02-08 encoder, divide 1..64
// - Sources 09-0f position, divide 1..64
// - Source 10 brake PWM, 11 inverted
// - Divider one gives pulse per increment
// - Brake control drives control word bit 0
// - Entries act only with routing enabled
`include "dor_map.svh"
module dor_route
    import dor_pkg::*;
(
    input  wire logic                        CLK,
    input  wire logic                        RESET,
    input  wire logic [3:0]                  ADDR,
    input  wire logic [31:0]                 WDATA,
    input  wire logic                        WR,
    input  wire logic                        RD,
    output      logic [31:0]                 RDATA,
    input  wire logic                        ENC_INC,
    input  wire logic                        POS_INC,
    input  wire logic                        BRAKE_REQ,
    output      logic [`DOR_NUM_OUT-1:0]     OUT_PIN
);
    ////////////////////////////////////////////////////////////////////////
    // Types and state
    typedef struct packed {
        dor_entry_t [`DOR_NUM_OUT-1:0] entry;  // Routing table
        logic                          route_en; // Routing enable
        logic [31:0]                   ctrl_word; // Output control word
        logic [15:0]                   brake_per; // Brake PWM period
        logic [15:0]                   brake_on;  // Brake PWM on time
        logic [15:0]                   brake_cnt; // Brake PWM phase
        logic                          brake_pwm; // Brake PWM level
        logic [31:0]                   rdata;     // Read answer
        logic [`DOR_NUM_OUT-1:0]       pins;      // Pin levels
    } dor_st_t;
    dor_st_t st, next_st;
    dor_bus_t bus;
    logic [`DOR_NUM_OUT-1:0] enc_tick;   // Divided encoder ticks
    logic [`DOR_NUM_OUT-1:0] pos_tick;   // Divided position ticks
    logic [`DOR_NUM_OUT-1:0] src_tick;   // Selected tick per output
    logic [`DOR_NUM_OUT-1:0] shaped;     // Rate limited pulses
    logic [`DOR_NUM_OUT-1:0] pin_val;    // Computed pin levels

    assign bus = '{WR, RD, ADDR, WDATA};

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Divider select from source code
    function automatic logic [2:0] div_sel(input logic [7:0] src);
        logic [7:0] d;
        d = 8'h00;
        if (src >= `DOR_SRC_POS_LO) begin
            d = src - `DOR_SRC_POS_LO;
        end else if (src >= `DOR_SRC_ENC_LO) begin
            d = src - `DOR_SRC_ENC_LO;
        end
        return d[2:0];
    endfunction : div_sel
    // Gating condition from entry and control word
    // bit 7 inverts sense
    function automatic logic gate_on(input dor_entry_t e, input logic [31:0] cw);
        logic b;
        b = cw[e.gate[`DOR_SEL_MSB:0]];
        return e.gate[`DOR_INV_BIT] ? ~b : b;
    endfunction : gate_on

    ////////////////////////////////////////////////////////////////////////
    // Per output pulse path
    genvar g;
    generate
        for (g = 0; g < `DOR_NUM_OUT; g++) begin : g_out
            dor_divider u_enc (
                .clk   (CLK),
                .reset (RESET),
                .inc   (ENC_INC),
                .sel   (div_sel(st.entry[g].src)),
                .tick  (enc_tick[g])
            );
            dor_divider u_pos (
                .clk   (CLK),
                .reset (RESET),
                .inc   (POS_INC),
                .sel   (div_sel(st.entry[g].src)),
                .tick  (pos_tick[g])
            );
            // Tick chosen by source range
            assign src_tick[g] =
                (st.entry[g].src >= `DOR_SRC_ENC_LO && st.entry[g].src <= `DOR_SRC_ENC_HI)
                    ? enc_tick[g] :
                (st.entry[g].src >= `DOR_SRC_POS_LO && st.entry[g].src <= `DOR_SRC_POS_HI)
                    ? pos_tick[g] : 1'b0;
            dor_shaper #(
                .GAP ((g == 0) ? `DOR_SWPWM_GAP : `DOR_OUT_GAP)
            ) u_shp (
                .clk   (CLK),
                .reset (RESET),
                .tick  (src_tick[g]),
                .pulse (shaped[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pin level selection
    always_comb begin
        for (int i = 0; i < `DOR_NUM_OUT; i++) begin
            pin_val[i] = 1'b0;
            if (st.route_en) begin
                if (st.entry[i] == `DOR_ENTRY_OFF) begin
                    pin_val[i] = 1'b0;
                end else if (!gate_on(st.entry[i], st.ctrl_word)) begin
                    pin_val[i] = 1'b0;
                end else begin
                    if (st.entry[i].src == `DOR_SRC_ONE) begin
                        pin_val[i] = 1'b1;
                    end else if (st.entry[i].src == `DOR_SRC_ZERO) begin
                        pin_val[i] = 1'b0;
                    end else if (st.entry[i].src == `DOR_SRC_BRAKE) begin
                        pin_val[i] = st.brake_pwm;
                    end else if (st.entry[i].src == `DOR_SRC_BRAKE_N) begin
                        pin_val[i] = ~st.brake_pwm;
                    end else begin
                        pin_val[i] = shaped[i];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: bus, brake PWM, pins
    always_comb begin
        next_st = st;
        next_st.rdata = 32'h00000000;
        // Brake PWM phase counter
        if (st.brake_cnt >= st.brake_per) begin
            next_st.brake_cnt = 16'h0000;
        end else begin
            next_st.brake_cnt = st.brake_cnt + 16'h0001;
        end
        next_st.brake_pwm = (st.brake_cnt < st.brake_on);
        // Register writes
        if (bus.wr) begin
            if (bus.addr < 4'(`DOR_NUM_OUT)) begin
                next_st.entry[bus.addr[1:0]] = bus.wdata[15:0];
            end else if (bus.addr == `DOR_IDX_CTRL) begin
                next_st.route_en = bus.wdata[`DOR_ROUTE_EN_BIT];
            end else if (bus.addr == `DOR_IDX_CTRLWORD) begin
                next_st.ctrl_word = bus.wdata;
            end else if (bus.addr == `DOR_IDX_BRAKE_PER) begin
                next_st.brake_per = bus.wdata[15:0];
            end else if (bus.addr == `DOR_IDX_BRAKE_ON) begin
                next_st.brake_on = bus.wdata[15:0];
            end
        end
        next_st.ctrl_word[`DOR_BRAKE_BIT] = BRAKE_REQ;
        // Register reads, unmapped read zero
        if (bus.rd) begin
            if (bus.addr < 4'(`DOR_NUM_OUT)) begin
                next_st.rdata = {16'h0000, st.entry[bus.addr[1:0]]};
            end else if (bus.addr == `DOR_IDX_CTRL) begin
                next_st.rdata = {31'h0, st.route_en};
            end else if (bus.addr == `DOR_IDX_CTRLWORD) begin
                next_st.rdata = st.ctrl_word;
            end else if (bus.addr == `DOR_IDX_PINS) begin
                next_st.rdata = {28'h0000000, st.pins};
            end else if (bus.addr == `DOR_IDX_BRAKE_PER) begin
                next_st.rdata = {16'h0000, st.brake_per};
            end else if (bus.addr == `DOR_IDX_BRAKE_ON) begin
                next_st.rdata = {16'h0000, st.brake_on};
            end
        end
        next_st.pins = pin_val;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK) begin
        if (RESET) begin
            st <= '0;
            for (int i = 0; i < `DOR_NUM_OUT; i++) begin
                st.entry[i] <= `DOR_ENTRY_RESET;
            end
        end else begin
            st <= next_st;
        end
    end

    assign RDATA   = st.rdata;
    assign OUT_PIN = st.pins;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_off_zero;
        @(posedge CLK) disable iff (RESET)
        (!st.route_en) |=> (OUT_PIN == '0);
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("Pins high with routing off");

    property p_ffff_zero;
        @(posedge CLK) disable iff (RESET)
        (st.entry[1] == 16'hffff) |=> !OUT_PIN[1];
    endproperty
    a_ffff_zero: assert property (p_ffff_zero) else $error("Disabled entry drives pin");

    property p_const_one;
        @(posedge CLK) disable iff (RESET)
        (st.route_en && st.entry[1].src == 8'h00 && gate_on(st.entry[1], st.ctrl_word))
            |=> OUT_PIN[1];
    endproperty
    a_const_one: assert property (p_const_one) else $error("Constant one missing");

    property p_const_zero;
        @(posedge CLK) disable iff (RESET)
        (st.entry[1].src == 8'h01) |=> !OUT_PIN[1];
    endproperty
    a_const_zero: assert property (p_const_zero) else $error("Constant zero broken");

    property p_gate_zero;
        @(posedge CLK) disable iff (RESET)
        (!gate_on(st.entry[1], st.ctrl_word)) |=> !OUT_PIN[1];
    endproperty
    a_gate_zero: assert property (p_gate_zero) else $error("Ungated pin high");

    property p_inv_gate;
        @(posedge CLK) disable iff (RESET)
        (st.route_en && st.entry[1].src == 8'h00 && st.entry[1].gate[7]
            && !st.ctrl_word[st.entry[1].gate[4:0]]) |=> OUT_PIN[1];
    endproperty
    a_inv_gate: assert property (p_inv_gate) else $error("Inverted gate failed");

    property p_brake_bit;
        @(posedge CLK) disable iff (RESET)
        BRAKE_REQ |=> st.ctrl_word[0];
    endproperty
    a_brake_bit: assert property (p_brake_bit) else $error("Brake bit not driven");

    property p_brake_src;
        @(posedge CLK) disable iff (RESET)
        (st.route_en && st.entry[2].src == 8'h11
            && (st.ctrl_word[st.entry[2].gate[4:0]] ^ st.entry[2].gate[7]))
            |=> (OUT_PIN[2] == !$past(st.brake_pwm));
    endproperty
    a_brake_src: assert property (p_brake_src) else $error("Inverted brake PWM wrong");

    property p_brake_pin;
        @(posedge CLK) disable iff (RESET)
        (st.route_en && st.entry[2].src == 8'h10
            && (st.ctrl_word[st.entry[2].gate[4:0]] ^ st.entry[2].gate[7]))
            |=> (OUT_PIN[2] == $past(st.brake_pwm));
    endproperty
    a_brake_pin: assert property (p_brake_pin) else $error("Brake PWM not routed");

    property p_read_lat;
        @(posedge CLK) disable iff (RESET)
        (RD && ADDR == 4'h8) |=> (RDATA == {31'h0, $past(st.route_en)});
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("Read data wrong");

    property p_wr_route;
        @(posedge CLK) disable iff (RESET)
        (WR && ADDR == 4'h8) |=> (st.route_en == $past(WDATA[0]));
    endproperty
    a_wr_route: assert property (p_wr_route) else $error("Routing enable not written");

    property p_read_entry;
        @(posedge CLK) disable iff (RESET)
        (RD && ADDR == 4'h1) |=> (RDATA == {16'h0, $past(st.entry[1])});
    endproperty
    a_read_entry: assert property (p_read_entry) else $error("Entry read wrong");

    property p_pwm_gate;
        @(posedge CLK) disable iff (RESET)
        !(st.ctrl_word[st.entry[0].gate[4:0]] ^ st.entry[0].gate[7]) |=> !OUT_PIN[0];
    endproperty
    a_pwm_gate: assert property (p_pwm_gate) else $error("Ungated soft PWM pin high");

    // Main scenarios reached
    c_enc: cover property (@(posedge CLK) disable iff (RESET)
        st.entry[0].src == 8'h02 && OUT_PIN[0]);
    c_pos: cover property (@(posedge CLK) disable iff (RESET)
        st.entry[0].src == 8'h0a && OUT_PIN[0]);
    c_pwm: cover property (@(posedge CLK) disable iff (RESET)
        st.entry[2].src == 8'h10 && OUT_PIN[2]);
    c_pwm_n: cover property (@(posedge CLK) disable iff (RESET)
        st.entry[2].src == 8'h11 && OUT_PIN[2]);
    c_inv: cover property (@(posedge CLK) disable iff (RESET)
        st.entry[1].gate[7] && OUT_PIN[1]);
endmodule : dor_route

//--- dv/dor_load.sv
////////////////////////////////////////////////////////////////////////////////
// Loads on the output pins; they only watch the levels they are given
module dor_load (
    input  wire logic             clk,
    input  wire logic [3:0]       pins,
    output      logic [3:0][15:0] rises,
    output      logic [3:0][15:0] width
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0]       prev     = 4'h0;  // Level seen at the last edge
    logic [3:0][15:0] run      = '0;    // Length of the current high time
    logic [3:0][15:0] rise_cnt = '0;    // Rising edges seen so far
    logic [3:0][15:0] high_len = '0;    // Length of the last finished high time

    assign rises = rise_cnt;
    assign width = high_len;

    ////////////////////////////////////////////////////////////////////////////////
    // Count rising edges and keep the length of the last high time
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (pins[i] && !prev[i]) begin
                rise_cnt[i] <= rise_cnt[i] + 16'h1;
            end
            if (pins[i]) begin
                run[i] <= run[i] + 16'h1;
            end else if (prev[i]) begin
                high_len[i] <= run[i];
                run[i]   <= '0;
            end
        end
        prev <= pins;
    end
endmodule : dor_load

//--- dv/dor_route_bench.sv
`include "dor_map.svh"
module dor_route_bench;
    import dor_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic             clk       = 1'b0;
    logic             reset     = 1'b1;
    logic [3:0]       addr      = 4'h0;
    logic [31:0]      wdata     = 32'h0;
    logic             wr        = 1'b0;
    logic             rd_s      = 1'b0;
    logic [31:0]      rdata;
    logic             enc_inc   = 1'b0;
    logic             pos_inc   = 1'b0;
    logic             brake_req = 1'b0;
    logic [3:0]       out_pin;
    logic [3:0][15:0] rises;
    logic [3:0][15:0] width;
    int               mismatches = 0;
    int               tests_run  = 0;
    // Constant source table: entry, control word, expected pin 1
    logic [15:0] ce [7] = '{16'h0005, 16'h0105, 16'h0005, 16'h0085, 16'h0085, 16'hffff, 16'h0185};
    logic [31:0] cw [7] = '{32'h20, 32'h20, 32'h0, 32'h0, 32'h20, 32'h20, 32'h0};
    logic        ex [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    // Brake table: entry, brake request, highs in two periods
    logic [15:0] be [4] = '{16'h1000, 16'h1100, 16'h1080, 16'h1080};
    logic        bq [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic [31:0] bn [4] = '{32'd6, 32'd14, 32'd0, 32'd6};

    always #20 clk = ~clk;

    dor_route dor_route_inst (
        .CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd_s),
        .RDATA(rdata), .ENC_INC(enc_inc), .POS_INC(pos_inc), .BRAKE_REQ(brake_req),
        .OUT_PIN(out_pin)
    );
    dor_load dor_load_inst (.clk(clk), .pins(out_pin), .rises(rises), .width(width));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One write cycle
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // One read cycle; data taken in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // Let a change reach the pins
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    // Final verdict
    task automatic print_verdict;
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog sized for the long pulse waits
    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [31:0] r;
        logic [3:0]  a;
        int          n;
        logic [15:0] r0;
        void'($urandom(27363));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        // Reset contents, then read data falls back to zero
        for (int i = 0; i < 4; i++) begin
            rd_reg(4'(i), r);
            check(r, 32'hffff);
        end
        @(posedge clk);
        #1 check(rdata, 32'h0);
        for (int i = 8; i < 13; i++) begin
            rd_reg(4'(i), r);
            check(r, 32'h0);
        end
        // Unmapped places read zero
        foreach (be[i]) begin
            rd_reg(4'(4 + i), r);
            check(r, 32'h0);
        end
        // Random entries and control words
        repeat (8) begin
            a = 4'($urandom_range(3, 0));
            d = $urandom();
            wr_reg(a, d);
            rd_reg(a, r);
            check(r, {16'h0, d[15:0]});
            @(posedge clk);
            brake_req <= 1'($urandom_range(1, 0));
            d = $urandom();
            wr_reg(`DOR_IDX_CTRLWORD, d);
            rd_reg(`DOR_IDX_CTRLWORD, r);
            check(r, {d[31:1], brake_req});
        end
        for (int i = 0; i < 4; i++) begin
            wr_reg(4'(i), `DOR_ENTRY_OFF);
        end
        brake_req <= 1'b0;
        // Constant sources, gating and inversion on output 1
        wr_reg(`DOR_IDX_CTRL, 32'h1);
        foreach (ce[i]) begin
            wr_reg(4'h1, {16'h0, ce[i]});
            wr_reg(`DOR_IDX_CTRLWORD, cw[i]);
            settle();
            check({31'h0, out_pin[1]}, {31'h0, ex[i]});
            rd_reg(`DOR_IDX_PINS, r);
            check(r, {30'h0, ex[i], 1'b0});
        end
        // Routing switched off silences a gated constant one
        wr_reg(4'h1, 32'h0005);
        wr_reg(`DOR_IDX_CTRLWORD, 32'h20);
        wr_reg(`DOR_IDX_CTRL, 32'h0);
        settle();
        check({31'h0, out_pin[1]}, 32'h0);
        wr_reg(`DOR_IDX_CTRL, 32'h1);
        wr_reg(4'h1, `DOR_ENTRY_OFF);
        // Brake PWM on output 2: ten cycle period, three high
        wr_reg(`DOR_IDX_CTRLWORD, 32'h0);
        wr_reg(`DOR_IDX_BRAKE_PER, 32'd9);
        wr_reg(`DOR_IDX_BRAKE_ON, 32'd3);
        foreach (be[i]) begin
            @(posedge clk);
            brake_req <= bq[i];
            wr_reg(4'h2, {16'h0, be[i]});
            settle();
            n = 0;
            repeat (20) begin
                @(posedge clk);
                #1 n += int'(out_pin[2]);
            end
            check(32'(n), bn[i]);
        end
        wr_reg(4'h2, `DOR_ENTRY_OFF);
        // Two back to back increments, divider one, on the software PWM pin
        wr_reg(`DOR_IDX_CTRLWORD, 32'h20);
        wr_reg(4'h0, 32'h0205);
        settle();
        r0 = rises[0];
        @(posedge clk);
        enc_inc <= 1'b1;
        repeat (2) @(posedge clk);
        enc_inc <= 1'b0;
        repeat (4 * `DOR_SWPWM_GAP + 40) @(posedge clk);
        check({16'h0, rises[0] - r0}, 32'd2);
        check({16'h0, width[0]}, `DOR_SWPWM_GAP);
        // Two position increments through divider two give one pulse
        wr_reg(4'h0, 32'h0a05);
        settle();
        r0 = rises[0];
        @(posedge clk);
        pos_inc <= 1'b1;
        @(posedge clk);
        pos_inc <= 1'b0;
        @(posedge clk);
        pos_inc <= 1'b1;
        @(posedge clk);
        pos_inc <= 1'b0;
        repeat (4 * `DOR_SWPWM_GAP + 40) @(posedge clk);
        check({16'h0, rises[0] - r0}, 32'd1);
        // Divide by 64: 127 encoder steps give a single pulse
        wr_reg(4'h0, 32'h0805);
        settle();
        r0 = rises[0];
        @(posedge clk);
        enc_inc <= 1'b1;
        repeat (127) @(posedge clk);
        enc_inc <= 1'b0;
        repeat (2 * `DOR_SWPWM_GAP + 40) @(posedge clk);
        check({16'h0, rises[0] - r0}, 32'd1);
        // Pulse source with its gate bit clear stays low
        wr_reg(4'h0, 32'h0206);
        settle();
        @(posedge clk);
        enc_inc <= 1'b1;
        @(posedge clk);
        enc_inc <= 1'b0;
        repeat (50) @(posedge clk);
        #1 check({31'h0, out_pin[0]}, 32'h0);
        print_verdict();
    end
endmodule : dor_route_bench
